// >>> include/debug_cmd_pkg.sv
// debug_cmd_pkg: constants and types shared by the debug command code decoder
// assumes: an AXI4-Lite master and a same-clock serial bit receiver around the block
package debug_cmd_pkg;

  // command code layout
  localparam int CODE_W      = 8;
  localparam int DIR_BIT     = 5;
  localparam int MEM_SEL_BIT = 4;
  localparam int SIZE_HI     = 3;
  localparam int SIZE_LO     = 2;
  localparam int ACC_HI      = 1;
  localparam int ACC_LO      = 0;
  localparam int GRP_HI      = 7;
  localparam int GRP_LO      = 6;
  localparam int NUM_HI      = 4;
  localparam int NUM_LO      = 0;
  localparam int BIT_CNT_W   = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

  // register groups
  localparam logic [1:0] GRP_MISC  = 2'h0;
  localparam logic [1:0] GRP_GPR   = 2'h1;
  localparam logic [1:0] GRP_DEBUG = 2'h2;
  localparam logic [1:0] GRP_CTRL  = 2'h3;

  // operand sizes and memory access types
  localparam logic [1:0] SIZE_BYTE   = 2'h0;
  localparam logic [1:0] SIZE_WORD   = 2'h1;
  localparam logic [1:0] SIZE_LONG   = 2'h2;
  localparam logic [1:0] ACC_PLAIN   = 2'h0;
  localparam logic [1:0] ACC_STATUS  = 2'h1;
  localparam logic [1:0] ACC_BLOCK   = 2'h2;
  localparam logic [1:0] ACC_BLOCK_S = 2'h3;

  // register numbers
  localparam logic [4:0] NUM_DATA_LAST = 5'h07;
  localparam logic [4:0] NUM_ADDR_LAST = 5'h0F;
  localparam logic [4:0] NUM_ALT_SP    = 5'h00;
  localparam logic [4:0] NUM_VBR       = 5'h01;
  localparam logic [4:0] NUM_CPU_CONFIGURATION_REGISTER     = 5'h02;
  localparam logic [4:0] NUM_PSW       = 5'h0E;
  localparam logic [4:0] NUM_PC        = 5'h0F;

  // bus map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CODE   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DECODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  localparam int CTRL_SER_EN_BIT = 0;
  localparam int STAT_ABORT_BIT  = 3;

  typedef enum logic [1:0] {CLS_MISC, CLS_MEMORY, CLS_REGISTER} cmdClass_type;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_DATA, TGT_ADDR, TGT_DEBUG, TGT_ALT_SP,
    TGT_VBR, TGT_CPU_CONFIGURATION_REGISTER, TGT_PSW, TGT_PC
  } target_type;

  // decoded command, 22 bits, read back zero-extended
  typedef struct packed {
    logic         reservedCode;
    logic [2:0]   regIndex;
    target_type   target;
    logic [4:0]   regNum;
    logic [1:0]   group;
    logic [1:0]   accessType;
    logic [1:0]   operandSize;
    cmdClass_type cmdClass;
    logic         isRead;
  } decode_type;

  // status word, 32 bits
  typedef struct packed {
    logic [15:0] cmdCount;
    logic [7:0]  partialCode;
    logic [3:0]  spare;
    logic        abortSeen;
    logic [2:0]  bitCount;
  } status_type;

endpackage

// >>> design/debug_code_decoder.sv
// debug_code_decoder: pure combinational split of one 8-bit command code
// assumes: caller registers the result; code is stable while it is used
`timescale 1ns/100ps
`default_nettype none
module debug_code_decoder (
  // command code in
  input  wire logic [debug_cmd_pkg::CODE_W-1:0] code,
  // decoded fields out
  output debug_cmd_pkg::decode_type             decoded
);

  logic [1:0] grp;
  logic [4:0] num;

  // field extraction and register mapping
  always_comb begin
    grp = code[debug_cmd_pkg::GRP_HI:debug_cmd_pkg::GRP_LO];
    num = code[debug_cmd_pkg::NUM_HI:debug_cmd_pkg::NUM_LO];
    decoded              = '0;
    decoded.isRead       = code[debug_cmd_pkg::DIR_BIT];
    decoded.operandSize  = code[debug_cmd_pkg::SIZE_HI:debug_cmd_pkg::SIZE_LO];
    decoded.accessType   = code[debug_cmd_pkg::ACC_HI:debug_cmd_pkg::ACC_LO];
    decoded.group        = grp;
    decoded.regNum       = num;
    decoded.target       = debug_cmd_pkg::TGT_NONE;
    if (grp == debug_cmd_pkg::GRP_MISC) begin
      decoded.cmdClass = code[debug_cmd_pkg::MEM_SEL_BIT] ? debug_cmd_pkg::CLS_MEMORY : debug_cmd_pkg::CLS_MISC;
      // size code 11 names no operand width
      decoded.reservedCode = code[debug_cmd_pkg::MEM_SEL_BIT] &&
                             (decoded.operandSize != debug_cmd_pkg::SIZE_BYTE) &&
                             (decoded.operandSize != debug_cmd_pkg::SIZE_WORD) &&
                             (decoded.operandSize != debug_cmd_pkg::SIZE_LONG);
    end else begin
      decoded.cmdClass = debug_cmd_pkg::CLS_REGISTER;
      case (grp)
        debug_cmd_pkg::GRP_GPR: begin
          if (num <= debug_cmd_pkg::NUM_DATA_LAST) begin
            decoded.target = debug_cmd_pkg::TGT_DATA;
          end else if (num <= debug_cmd_pkg::NUM_ADDR_LAST) begin
            decoded.target = debug_cmd_pkg::TGT_ADDR;
          end
          decoded.regIndex = num[2:0];
        end
        debug_cmd_pkg::GRP_DEBUG: begin
          decoded.target = debug_cmd_pkg::TGT_DEBUG;
        end
        default: begin
          if (num == debug_cmd_pkg::NUM_ALT_SP) begin
            decoded.target = debug_cmd_pkg::TGT_ALT_SP;
          end else if (num == debug_cmd_pkg::NUM_VBR) begin
            decoded.target = debug_cmd_pkg::TGT_VBR;
          end else if (num == debug_cmd_pkg::NUM_CPU_CONFIGURATION_REGISTER) begin
            decoded.target = debug_cmd_pkg::TGT_CPU_CONFIGURATION_REGISTER;
          end else if (num == debug_cmd_pkg::NUM_PSW) begin
            decoded.target = debug_cmd_pkg::TGT_PSW;
          end else if (num == debug_cmd_pkg::NUM_PC) begin
            decoded.target = debug_cmd_pkg::TGT_PC;
          end
        end
      endcase
      // unmapped numbers select nothing and are flagged
      decoded.reservedCode = (decoded.target == debug_cmd_pkg::TGT_NONE);
    end
  end

endmodule // debug_code_decoder
`default_nettype wire

// >>> design/debug_command_code_decoder.sv
// debug_command_code_decoder: collects the 8-bit debug command code, decodes it and
// holds the result for the command sequencer; registers reachable over AXI4-Lite
// assumes: serial bits arrive from a bit receiver on ref_clk, one strobe per bit
`timescale 1ns/100ps
`default_nettype none
module debug_command_code_decoder #(
  parameter int CMD_COUNT_W = 16
) (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rstn,
  // serial command bits from the bit receiver
  input  wire logic                              bitStrobe,
  input  wire logic                              bitData,
  input  wire logic                              linkAbort,
  // decoded command towards the sequencer
  output debug_cmd_pkg::decode_type              cmdDecoded,
  output logic [debug_cmd_pkg::CODE_W-1:0]       cmdCode,
  output logic                                   cmdStrobe,
  // axi4-lite write address and data
  input  wire logic [debug_cmd_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  // axi4-lite read
  input  wire logic [debug_cmd_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready
);

  // reset release synchroniser; assertion stays asynchronous
  logic rstMeta_reg;
  logic rstSync_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // serial collection and decode state
  logic [debug_cmd_pkg::CODE_W-1:0]    shift_reg,    shift_next;
  logic [debug_cmd_pkg::BIT_CNT_W-1:0] bitCount_reg, bitCount_next;
  logic [debug_cmd_pkg::CODE_W-1:0]    code_reg,     code_next;
  debug_cmd_pkg::decode_type           decode_reg,   decode_next;
  logic                                strobe_reg,   strobe_next;
  logic                                abort_reg,    abort_next;
  logic [CMD_COUNT_W-1:0]              count_reg,    count_next;
  logic [31:0]                         ctrl_reg,     ctrl_next;

  // bus state
  logic                             awReady_reg, awReady_next;
  logic                             wReady_reg,  wReady_next;
  logic [debug_cmd_pkg::ADDR_W-1:0] awAddr_reg,  awAddr_next;
  logic [31:0]                      wData_reg,   wData_next;
  logic [3:0]                       wStrb_reg,   wStrb_next;
  logic                             bValid_reg,  bValid_next;
  logic [1:0]                       bResp_reg,   bResp_next;
  logic                             arReady_reg, arReady_next;
  logic                             rValid_reg,  rValid_next;
  logic [31:0]                      rData_reg,   rData_next;
  logic [1:0]                       rResp_reg,   rResp_next;

  // completed code and its decode
  logic [debug_cmd_pkg::CODE_W-1:0] fullCode;
  logic                             serialDone;
  logic                             swCodeWrite;
  logic                             abortClear;
  logic [debug_cmd_pkg::CODE_W-1:0] decodeSrc;
  debug_cmd_pkg::decode_type        decodeComb;
  debug_cmd_pkg::status_type        statusWord;
  logic                             writeFire;

  debug_code_decoder u_decoder (
    .code    (decodeSrc),
    .decoded (decodeComb)
  );

  // byte-lane merge for writes into a full register word
  function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // write is performed once both address and data are held
  assign writeFire = !awReady_reg && !wReady_reg && !bValid_reg;
  assign fullCode  = {shift_reg[debug_cmd_pkg::CODE_W-2:0], bitData};
  assign serialDone = bitStrobe && ctrl_reg[debug_cmd_pkg::CTRL_SER_EN_BIT] && !linkAbort &&
                      (bitCount_reg == debug_cmd_pkg::LAST_BIT);
  assign swCodeWrite = writeFire && (awAddr_reg == debug_cmd_pkg::OFF_CODE) && wStrb_reg[0];
  assign abortClear  = writeFire && (awAddr_reg == debug_cmd_pkg::OFF_STATUS) && wStrb_reg[0] &&
                       wData_reg[debug_cmd_pkg::STAT_ABORT_BIT];
  // serial code wins over a software injection in the same cycle
  assign decodeSrc = serialDone ? fullCode : wData_reg[debug_cmd_pkg::CODE_W-1:0];

  // status word assembled from live state
  always_comb begin
    statusWord             = '0;
    statusWord.cmdCount    = 16'(count_reg);
    statusWord.partialCode = shift_reg;
    statusWord.abortSeen   = abort_reg;
    statusWord.bitCount    = bitCount_reg;
  end

  // next state of the command path
  always_comb begin
    shift_next    = shift_reg;
    bitCount_next = bitCount_reg;
    code_next     = code_reg;
    decode_next   = decode_reg;
    strobe_next   = 1'b0;
    abort_next    = abort_reg;
    count_next    = count_reg;
    ctrl_next     = ctrl_reg;
    if (linkAbort) begin
      // an aborted bit stream leaves no partial code behind
      shift_next    = '0;
      bitCount_next = '0;
    end else if (bitStrobe && ctrl_reg[debug_cmd_pkg::CTRL_SER_EN_BIT]) begin
      shift_next    = fullCode;
      bitCount_next = bitCount_reg + 1'b1;
    end
    // a code is decoded once all eight bits are in, or when software writes the code register
    if (serialDone || swCodeWrite) begin
      code_next   = decodeSrc;
      decode_next = decodeComb;
      strobe_next = 1'b1;
      count_next  = count_reg + 1'b1;
    end
    // abort flag: a new abort wins over a clear in the same cycle
    if (linkAbort) begin
      abort_next = 1'b1;
    end else if (abortClear) begin
      abort_next = 1'b0;
    end
    if (writeFire && (awAddr_reg == debug_cmd_pkg::OFF_CTRL)) begin
      ctrl_next = mergeLanes(ctrl_reg, wData_reg, wStrb_reg);
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      shift_reg    <= '0;
      bitCount_reg <= '0;
      code_reg     <= '0;
      decode_reg   <= '0;
      strobe_reg   <= 1'b0;
      abort_reg    <= 1'b0;
      count_reg    <= '0;
      ctrl_reg     <= debug_cmd_pkg::CTRL_RESET;
    end else begin
      shift_reg    <= shift_next;
      bitCount_reg <= bitCount_next;
      code_reg     <= code_next;
      decode_reg   <= decode_next;
      strobe_reg   <= strobe_next;
      abort_reg    <= abort_next;
      count_reg    <= count_next;
      ctrl_reg     <= ctrl_next;
    end
  end

  // next state of the bus slave; aw and w are taken in either order
  always_comb begin
    awReady_next = awReady_reg;
    wReady_next  = wReady_reg;
    awAddr_next  = awAddr_reg;
    wData_next   = wData_reg;
    wStrb_next   = wStrb_reg;
    bValid_next  = bValid_reg;
    bResp_next   = bResp_reg;
    arReady_next = arReady_reg;
    rValid_next  = rValid_reg;
    rData_next   = rData_reg;
    rResp_next   = rResp_reg;
    if (s_axi_awvalid && awReady_reg) begin
      awAddr_next  = s_axi_awaddr;
      awReady_next = 1'b0;
    end
    if (s_axi_wvalid && wReady_reg) begin
      wData_next  = s_axi_wdata;
      wStrb_next  = s_axi_wstrb;
      wReady_next = 1'b0;
    end
    if (writeFire) begin
      bValid_next = 1'b1;
      if ((awAddr_reg == debug_cmd_pkg::OFF_CODE) || (awAddr_reg == debug_cmd_pkg::OFF_DECODE) ||
          (awAddr_reg == debug_cmd_pkg::OFF_CTRL) || (awAddr_reg == debug_cmd_pkg::OFF_STATUS)) begin
        bResp_next = debug_cmd_pkg::RESP_OKAY;
      end else begin
        bResp_next = debug_cmd_pkg::RESP_SLVERR;
      end
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next  = 1'b0;
      awReady_next = 1'b1;
      wReady_next  = 1'b1;
    end
    // reads: one outstanding, arready drops until the data is taken
    if (s_axi_arvalid && arReady_reg) begin
      arReady_next = 1'b0;
      rValid_next  = 1'b1;
      rResp_next   = debug_cmd_pkg::RESP_OKAY;
      if (s_axi_araddr == debug_cmd_pkg::OFF_CODE) begin
        rData_next = 32'(code_reg);
      end else if (s_axi_araddr == debug_cmd_pkg::OFF_DECODE) begin
        rData_next = 32'(decode_reg);
      end else if (s_axi_araddr == debug_cmd_pkg::OFF_CTRL) begin
        rData_next = ctrl_reg;
      end else if (s_axi_araddr == debug_cmd_pkg::OFF_STATUS) begin
        rData_next = statusWord;
      end else begin
        rData_next = '0;
        rResp_next = debug_cmd_pkg::RESP_SLVERR;
      end
    end
    if (rValid_reg && s_axi_rready) begin
      rValid_next  = 1'b0;
      arReady_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_reg) begin
    if (!rstSync_reg) begin
      awReady_reg <= 1'b1;
      wReady_reg  <= 1'b1;
      awAddr_reg  <= '0;
      wData_reg   <= '0;
      wStrb_reg   <= '0;
      bValid_reg  <= 1'b0;
      bResp_reg   <= debug_cmd_pkg::RESP_OKAY;
      arReady_reg <= 1'b1;
      rValid_reg  <= 1'b0;
      rData_reg   <= '0;
      rResp_reg   <= debug_cmd_pkg::RESP_OKAY;
    end else begin
      awReady_reg <= awReady_next;
      wReady_reg  <= wReady_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      arReady_reg <= arReady_next;
      rValid_reg  <= rValid_next;
      rData_reg   <= rData_next;
      rResp_reg   <= rResp_next;
    end
  end

  // all outputs straight from flip-flops
  assign cmdDecoded    = decode_reg;
  assign cmdCode       = code_reg;
  assign cmdStrobe     = strobe_reg;
  assign s_axi_awready = awReady_reg;
  assign s_axi_wready  = wReady_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;

endmodule // debug_command_code_decoder
`default_nettype wire

// >>> verification/debug_cmd_checker.sv
// debug_cmd_checker: concurrent checks on the decoded command outputs
// assumes: bound to debug_command_code_decoder, one ref_clk domain
`timescale 1ns/100ps
`default_nettype none
module debug_cmd_checker (
  // clock and reset
  input wire logic                                 ref_clk,
  input wire logic                                 rstn,
  // serial link and decode result
  input wire logic                                 bitStrobe,
  input wire logic                                 linkAbort,
  input wire debug_cmd_pkg::decode_type            cmdDecoded,
  input wire logic [debug_cmd_pkg::CODE_W-1:0]     cmdCode,
  input wire logic                                 cmdStrobe,
  // write response
  input wire logic                                 s_axi_bvalid
);
  logic [1:0]               grp;
  debug_cmd_pkg::target_type ctrlTgt;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // control group target worked out from the code, none for reserved numbers
  assign grp = cmdCode[7:6];
  always_comb begin
    case (cmdCode[4:0])
      5'h00:   ctrlTgt = debug_cmd_pkg::TGT_ALT_SP;
      5'h01:   ctrlTgt = debug_cmd_pkg::TGT_VBR;
      5'h02:   ctrlTgt = debug_cmd_pkg::TGT_CPU_CONFIGURATION_REGISTER;
      5'h0E:   ctrlTgt = debug_cmd_pkg::TGT_PSW;
      5'h0F:   ctrlTgt = debug_cmd_pkg::TGT_PC;
      default: ctrlTgt = debug_cmd_pkg::TGT_NONE;
    endcase
  end

  AST_STROBE_ONE: assert property (cmdStrobe |=> !cmdStrobe)
    else $error("cmdStrobe longer than one cycle");
  AST_STROBE_CAUSE: assert property (cmdStrobe |-> $past(bitStrobe) || $rose(s_axi_bvalid))
    else $error("cmdStrobe without a last bit or code write");
  AST_ABORT_DROPS: assert property (linkAbort |=> !cmdStrobe)
    else $error("code completed right after abort");
  AST_CODE_HOLDS: assert property (!cmdStrobe |-> $stable(cmdCode) && $stable(cmdDecoded))
    else $error("decode changed without cmdStrobe");
  AST_DIRECTION: assert property (cmdStrobe |-> cmdDecoded.isRead == cmdCode[5])
    else $error("direction bit mismatch");
  AST_MEM_SIZE: assert property (cmdStrobe && grp == 2'h0 && cmdCode[4]
    |-> cmdDecoded.cmdClass == debug_cmd_pkg::CLS_MEMORY && cmdDecoded.operandSize == cmdCode[3:2])
    else $error("memory size mismatch");
  AST_MEM_ACCESS: assert property (cmdStrobe && grp == 2'h0 && cmdCode[4]
    |-> cmdDecoded.accessType == cmdCode[1:0])
    else $error("memory access type mismatch");
  AST_REG_GROUP: assert property (cmdStrobe && grp != 2'h0 |-> cmdDecoded.cmdClass == debug_cmd_pkg::CLS_REGISTER
    && cmdDecoded.group == grp && cmdDecoded.regNum == cmdCode[4:0])
    else $error("register group or number mismatch");
  AST_GPR_TARGET: assert property (cmdStrobe && grp == 2'h1 && !cmdCode[4] |-> cmdDecoded.target ==
    (cmdCode[3] ? debug_cmd_pkg::TGT_ADDR : debug_cmd_pkg::TGT_DATA))
    else $error("general register target mismatch");
  AST_DEBUG_TARGET: assert property (cmdStrobe && grp == 2'h2 |-> cmdDecoded.target == debug_cmd_pkg::TGT_DEBUG)
    else $error("debug register target mismatch");
  AST_CTRL_TARGET: assert property (cmdStrobe && grp == 2'h3 |-> cmdDecoded.target == ctrlTgt
    && cmdDecoded.reservedCode == (ctrlTgt == debug_cmd_pkg::TGT_NONE))
    else $error("control register target mismatch");

  // main scenarios seen
  COV_MEMORY: cover property (cmdStrobe && cmdDecoded.cmdClass == debug_cmd_pkg::CLS_MEMORY);
  COV_CTRL: cover property (cmdStrobe && grp == 2'h3);
  COV_ABORT: cover property (linkAbort ##1 bitStrobe);
endmodule // debug_cmd_checker

bind debug_command_code_decoder debug_cmd_checker u_chk (.*);
`default_nettype wire

// >>> verification/debug_pod_model.sv
// debug_pod_model: behavioural host pod sending command bits to the decoder
// assumes: shares ref_clk with the decoder; tasks are entered just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module debug_pod_model (
  // clock
  input  wire logic ref_clk,
  // serial link towards the decoder
  output logic      bitStrobe,
  output logic      bitData,
  output logic      linkAbort
);
  logic bitVal  = 1'b0;
  logic idlePat = 1'b0;

  initial begin
    bitStrobe = 1'b0;
    linkAbort = 1'b0;
  end

  // outside a bit the data line toggles, so a stale bit never looks valid
  always @(posedge ref_clk) idlePat <= ~idlePat;
  assign bitData = bitStrobe ? bitVal : idlePat;

  // first n bits of a code, msb first, one per cycle
  task automatic send_bits(input logic [7:0] c, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      bitStrobe <= 1'b1;
      bitVal    <= c[i];
      @(posedge ref_clk);
    end
  endtask

  task automatic idle();
    bitStrobe <= 1'b0;
    @(posedge ref_clk);
  endtask

  // link timeout for one cycle
  task automatic abort_link();
    bitStrobe <= 1'b0;
    linkAbort <= 1'b1;
    @(posedge ref_clk);
    linkAbort <= 1'b0;
  endtask
endmodule // debug_pod_model
`default_nettype wire

// >>> verification/debug_command_code_decoder_tb.sv
// debug_command_code_decoder_tb: bus and link tests of the command decoder
// assumes: pod model and checker compiled alongside, 10 MHz ref_clk
`timescale 1ns/100ps
`default_nettype none
module debug_command_code_decoder_tb;
  logic                      ref_clk = 1'b0;
  logic                      rstn    = 1'b0;
  logic                      bitStrobe, bitData, linkAbort, cmdStrobe;
  debug_cmd_pkg::decode_type cmdDecoded;
  logic [7:0]                cmdCode, expC;
  logic [7:0]                s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]               s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]                s_axi_wstrb = 4'hF;
  logic                      s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                      s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                      s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]                s_axi_bresp, s_axi_rresp;
  logic [7:0]                expQ[$];
  int                        num_errors = 0;
  int                        checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  // every port has a bench signal of the same name
  debug_command_code_decoder u_dut (.*);

  debug_pod_model u_pod (.*);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // write with full strobes; a trailing edge keeps two calls from colliding
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = debug_cmd_pkg::RESP_OKAY);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge ref_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end while (!(da && dw));
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = debug_cmd_pkg::RESP_OKAY);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // expected decode of one code; fields the design leaves open are masked off
  task automatic chk_dec(input logic [7:0] c);
    debug_cmd_pkg::decode_type e;
    logic [21:0]               m;
    e = '0;
    m = 22'h000007;
    e.isRead = c[5];
    if (c[7:6] != 2'h0) begin
      m = 22'h23FF87;
      e.cmdClass = debug_cmd_pkg::CLS_REGISTER;
      e.group = c[7:6];
      e.regNum = c[4:0];
      if (c[7:6] == 2'h1 && !c[4]) e.target = c[3] ? debug_cmd_pkg::TGT_ADDR : debug_cmd_pkg::TGT_DATA;
      if (c[7:6] == 2'h2) e.target = debug_cmd_pkg::TGT_DEBUG;
      if (c[7:6] == 2'h3) begin
        case (c[4:0])
          5'h00:   e.target = debug_cmd_pkg::TGT_ALT_SP;
          5'h01:   e.target = debug_cmd_pkg::TGT_VBR;
          5'h02:   e.target = debug_cmd_pkg::TGT_CPU_CONFIGURATION_REGISTER;
          5'h0E:   e.target = debug_cmd_pkg::TGT_PSW;
          5'h0F:   e.target = debug_cmd_pkg::TGT_PC;
          default: e.target = debug_cmd_pkg::TGT_NONE;
        endcase
      end
      e.reservedCode = (e.target == debug_cmd_pkg::TGT_NONE);
    end else if (c[4]) begin
      m = 22'h20007F;
      e.cmdClass = debug_cmd_pkg::CLS_MEMORY;
      e.operandSize = c[3:2];
      e.accessType = c[1:0];
      e.reservedCode = (c[3:2] == 2'h3);
    end
    chk("cmdCode", {24'h0, c}, {24'h0, cmdCode});
    chk("cmdDecoded", 32'(e & m), 32'(cmdDecoded & m));
  endtask

  // every completed code is matched against the queue of codes sent
  always @(negedge ref_clk) begin
    if (cmdStrobe === 1'b1) begin
      if (expQ.size() == 0) begin
        num_errors++;
        $display("[ERR] cmdStrobe exp none got %h", cmdCode);
      end else begin
        expC = expQ.pop_front();
        chk_dec(expC);
      end
    end
  end

  task automatic wrap_up();
    chk("codes pending", 32'h0, 32'(expQ.size()));
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge ref_clk);
    num_errors++;
    $display("[ERR] watchdog exp done got timeout");
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk("cmdDecoded rst", 32'h0, 32'(cmdDecoded));
    axi_rd(debug_cmd_pkg::OFF_CTRL, rd);
    chk("ctrl rst", debug_cmd_pkg::CTRL_RESET, rd);
    // every code value back to back, reserved numbers included
    for (int i = 0; i < 256; i++) begin
      expQ.push_back(8'(i));
      u_pod.send_bits(8'(i), 8);
    end
    u_pod.idle();
    axi_rd(debug_cmd_pkg::OFF_STATUS, rd);
    chk("cmd count", 32'h0000_0100, {16'h0, rd[31:16]});
    // timeout in mid-code drops the partial bits
    u_pod.send_bits(8'hA5, 4);
    u_pod.abort_link();
    expQ.push_back(8'hEF);
    u_pod.send_bits(8'hEF, 8);
    u_pod.idle();
    axi_rd(debug_cmd_pkg::OFF_STATUS, rd);
    chk("abort set", 32'h8, {28'h0, rd[3:0]});
    axi_wr(debug_cmd_pkg::OFF_STATUS, 32'h8);
    axi_rd(debug_cmd_pkg::OFF_STATUS, rd);
    chk("abort clear", 32'h0, {28'h0, rd[3:0]});
    // link switched off: bits are ignored
    axi_wr(debug_cmd_pkg::OFF_CTRL, 32'h0);
    u_pod.send_bits(8'h33, 8);
    u_pod.idle();
    axi_wr(debug_cmd_pkg::OFF_CTRL, debug_cmd_pkg::CTRL_RESET);
    // code injected by software, read back raw and decoded
    expQ.push_back(8'h6A);
    axi_wr(debug_cmd_pkg::OFF_CODE, 32'h6A);
    axi_rd(debug_cmd_pkg::OFF_CODE, rd);
    chk("code rd", 32'h6A, rd);
    axi_rd(debug_cmd_pkg::OFF_DECODE, rd);
    chk("decode rd", 32'h0000_9485, rd & 32'hFFE3_FF87);
    axi_wr(8'h10, 32'h1, debug_cmd_pkg::RESP_SLVERR);
    axi_rd(8'h10, rd, debug_cmd_pkg::RESP_SLVERR);
    chk("unmapped rd", 32'h0, rd);
    repeat (4) @(posedge ref_clk);
    wrap_up();
  end
endmodule // debug_command_code_decoder_tb
`default_nettype wire
